// *** smc_pkg.sv ***
`default_nettype none
package smc_pkg;
  // ------------------------------------------
  // timing counts
  // ------------------------------------------
  localparam int unsigned RESET_CYCLES = 5;
  localparam int unsigned EXEC_CYCLES  = 8;
  localparam logic [3:0]  RST_LAST     = 4'(RESET_CYCLES - 1);
  localparam logic [3:0]  EXEC_LAST    = 4'(EXEC_CYCLES - 1);

  // ------------------------------------------
  // stack geometry and constants
  // ------------------------------------------
  localparam int unsigned ST_W      = 128;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned LOW_W     = ST_W - 32;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [1:0]  BUF_FULL  = 2'h2;
  localparam logic [31:0] UNDEF_ENT = 32'h0000_0000;
  localparam logic [15:0] UNDEF_WRD = 16'h0000;
  localparam logic [31:0] PI_CONST  = 32'h02C9_0FDB;
  localparam logic [31:0] SIGN_MASK = 32'h8000_0000;
  localparam logic [7:0]  STAT_RST  = 8'h00;

  // ------------------------------------------
  // operation codes, service bit excluded
  // ------------------------------------------
  localparam logic [6:0] OP_NOP = 7'h00, OP_FLOAT_ROOT = 7'h01, OP_FLOAT_SIN = 7'h02;
  localparam logic [6:0] OP_FLOAT_COS = 7'h03, OP_FLOAT_TAN = 7'h04, OP_FLOAT_ASIN = 7'h05;
  localparam logic [6:0] OP_FLOAT_ACOS = 7'h06, OP_FLOAT_ATAN = 7'h07, OP_FLOAT_LOG10 = 7'h08;
  localparam logic [6:0] OP_FLOAT_LN = 7'h09, OP_FLOAT_EXP = 7'h0A, OP_FLOAT_POWER = 7'h0B;
  localparam logic [6:0] OP_FLOAT_ADD = 7'h10, OP_FLOAT_SUB = 7'h11, OP_FLOAT_MUL = 7'h12;
  localparam logic [6:0] OP_FLOAT_DIV = 7'h13, OP_FLOAT_NEGATE = 7'h15, OP_FLOAT_DUP = 7'h17;
  localparam logic [6:0] OP_FLOAT_POP = 7'h18, OP_FLOAT_SWAP = 7'h19, OP_PUSH_PI = 7'h1A;
  localparam logic [6:0] OP_LONG_TO_FLOAT = 7'h1C, OP_SHORT_TO_FLOAT = 7'h1D;
  localparam logic [6:0] OP_FLOAT_TO_SHORT = 7'h1F, OP_FLOAT_TO_LONG = 7'h3E;
  localparam logic [6:0] OP_LONG_ADD = 7'h2C, OP_LONG_SUB = 7'h2D, OP_LONG_MUL_LOW = 7'h2E;
  localparam logic [6:0] OP_LONG_MUL_HIGH = 7'h36, OP_LONG_DIV = 7'h2F, OP_LONG_NEGATE = 7'h34;
  localparam logic [6:0] OP_LONG_DUP = 7'h37, OP_LONG_POP = 7'h38, OP_LONG_SWAP = 7'h39;
  localparam logic [6:0] OP_SHORT_ADD = 7'h6C, OP_SHORT_SUB = 7'h6D, OP_SHORT_MUL_LOW = 7'h6E;
  localparam logic [6:0] OP_SHORT_MUL_HIGH = 7'h76, OP_SHORT_DIV = 7'h6F;
  localparam logic [6:0] OP_SHORT_NEGATE = 7'h74, OP_SHORT_DUP = 7'h77;
  localparam logic [6:0] OP_SHORT_POP = 7'h78, OP_SHORT_SWAP = 7'h79;

  // ------------------------------------------
  // carriers and states
  // ------------------------------------------
  typedef struct packed {
    logic       svc;
    logic       single;
    logic       fixed;
    logic [4:0] op;
  } smc_cmd_s;

  typedef struct packed {
    logic       busy;
    logic       sign;
    logic       zero;
    logic [3:0] err;
    logic       carry;
  } smc_status_s;

  typedef struct packed {
    logic       is_cmd;
    logic [7:0] value;
  } smc_entry_s;

  typedef enum logic [1:0] {
    ENG_RESET = 2'b00,
    ENG_IDLE  = 2'b01,
    ENG_EXEC  = 2'b10
  } smc_eng_e;
endpackage
`default_nettype wire

// *** smc_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_flag (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  // ------------------------------------------
  // sticky flag
  // ------------------------------------------
  // set beats clear so a completion in the ack cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

  a_flag_set_wins:
    assert property (@(posedge clk_i) disable iff (rst_i) set_i |=> flag_o)
    else $error("flag lost a set");
endmodule
`default_nettype wire

// *** smc_skid_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_skid_buf import smc_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire smc_entry_s in_data_i,
  output logic            out_valid_o,
  input  wire logic       out_ready_i,
  output smc_entry_s      out_data_o
);
  // ------------------------------------------
  // two-entry queue
  // ------------------------------------------
  smc_entry_s mem_q [BUF_DEPTH];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  logic       push;
  logic       pop;

  assign in_ready_o  = (cnt_q != BUF_FULL);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage, no reset needed: read only when counted valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule
`default_nettype wire

// *** smc_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_port import smc_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cs_n_i,
  input  wire logic       cmd_data_select_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  input  wire logic       done_ack_n_i,
  input  wire logic       svc_ack_n_i,
  output logic            done_n_o,
  output logic            done_oe_o,
  output logic            svc_request_o,
  output logic            ready_o
);
  // ------------------------------------------
  // declarations
  // ------------------------------------------
  logic            cs_q, sel_q, rd_q, wr_q;
  logic      [7:0] din_q;
  logic            wr_act, rd_act, rd_dat;
  logic            wr_act_q, rd_act_q, acc_start;
  smc_entry_s      wr_ent_q;
  logic            commit, in_rdy, out_vld, out_rdy;
  smc_entry_s      out_ent;
  smc_eng_e        eng_q;
  logic      [3:0] cnt_q;
  logic            take, cmd_take, push_take, done_pulse;
  smc_cmd_s        cmd_q;
  smc_status_s     stat_q;
  logic [ST_W-1:0] st_q, st_nx;
  logic            latched_q, rd_move, stall;
  logic      [7:0] rd_latch_q;
  logic            sign_nx, zero_nx, carry_nx;

  // ------------------------------------------
  // pin sampling
  // ------------------------------------------
  // one register stage on the select, strobe and data pins that feed transfer decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_q  <= 1'b1;
      sel_q <= 1'b0;
      rd_q  <= 1'b1;
      wr_q  <= 1'b1;
      din_q <= 8'h00;
    end else begin
      cs_q  <= cs_n_i;
      sel_q <= cmd_data_select_i;
      rd_q  <= rd_n_i;
      wr_q  <= wr_n_i;
      din_q <= data_i;
    end
  end

  // transfer decode
  assign wr_act    = !cs_q && !wr_q;
  assign rd_act    = !cs_q && !rd_q;
  assign rd_dat    = rd_act && !sel_q;
  assign acc_start = (wr_act && !wr_act_q) || (rd_act && !rd_act_q);
  assign commit    = wr_act_q && !wr_act;

  // write byte is kept while strobe is low, taken on release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_ent_q <= '0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        wr_ent_q <= '{is_cmd: sel_q, value: din_q};
      end
    end
  end

  // ------------------------------------------
  // write queue
  // ------------------------------------------
  smc_skid_buf u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (commit),
    .in_ready_o  (in_rdy),
    .in_data_i   (wr_ent_q),
    .out_valid_o (out_vld),
    .out_ready_i (out_rdy),
    .out_data_o  (out_ent)
  );

  assign out_rdy   = (eng_q == ENG_IDLE) && !rst_i;
  assign take      = out_vld && out_rdy;
  assign cmd_take  = take && out_ent.is_cmd;
  assign push_take = take && !out_ent.is_cmd;
  assign rd_move   = rd_dat && !latched_q && out_rdy && !out_vld;

  // ------------------------------------------
  // execution engine
  // ------------------------------------------
  assign done_pulse = (eng_q == ENG_EXEC) && (cnt_q == EXEC_LAST) && !rst_i;

  // reset holds the engine five cycles, then idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_q <= ENG_RESET;
      cnt_q <= 4'h0;
    end else begin
      unique case (eng_q)
        ENG_RESET: begin
          if (cnt_q == RST_LAST) begin
            eng_q <= ENG_IDLE;
            cnt_q <= 4'h0;
          end else begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end
        end
        ENG_IDLE: begin
          if (cmd_take) begin
            eng_q <= ENG_EXEC;
            cnt_q <= 4'h0;
          end
        end
        ENG_EXEC: begin
          if (cnt_q == EXEC_LAST) begin
            eng_q <= ENG_IDLE;
            cnt_q <= 4'h0;
          end else begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end
        end
        default: begin
          eng_q <= ENG_IDLE;
          cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // command register survives reset on purpose
  always_ff @(posedge clk_i) begin
    if (cmd_take) begin
      cmd_q <= smc_cmd_s'(out_ent.value);
    end
  end

  // status: busy from take to finish, flags at finish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= smc_status_s'(STAT_RST);
    end else if (cmd_take) begin
      stat_q.busy <= 1'b1;
    end else if (done_pulse) begin
      stat_q.busy  <= 1'b0;
      stat_q.sign  <= sign_nx;
      stat_q.zero  <= zero_nx;
      stat_q.carry <= carry_nx;
    end
  end

  // ------------------------------------------
  // stack and read latch
  // ------------------------------------------
  // no reset: contents must survive a reset
  always_ff @(posedge clk_i) begin
    if (push_take) begin
      st_q <= {out_ent.value, st_q[ST_W-1:BYTE_W]};
    end else if (rd_move) begin
      st_q <= {st_q[ST_W-BYTE_W-1:0], st_q[ST_W-1 -: BYTE_W]};
    end else if (done_pulse) begin
      st_q <= st_nx;
    end
  end

  // latched flag drops when the read strobe ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_q  <= 1'b0;
      rd_latch_q <= 8'h00;
    end else if (rd_move) begin
      latched_q  <= 1'b1;
      rd_latch_q <= st_q[ST_W-1 -: BYTE_W];
    end else if (!rd_dat) begin
      latched_q  <= 1'b0;
    end
  end

  // ------------------------------------------
  // operation decode
  // ------------------------------------------
  function automatic logic [15:0] wd(input logic [ST_W-1:0] s, input int k);
    return s[ST_W-1-WORD_W*k -: WORD_W];
  endfunction

  function automatic logic [31:0] en(input logic [ST_W-1:0] s, input int k);
    return s[ST_W-1-2*WORD_W*k -: 2*WORD_W];
  endfunction

  logic        [31:0] ea, eb, ec, ed, fres, q32;
  logic        [15:0] w0, w1, q16;
  logic signed [63:0] sa, sb;
  logic signed [31:0] sw0, sw1;
  logic        [63:0] p32;
  logic        [31:0] p16;
  logic        [32:0] sum33, dif33;
  logic        [16:0] sum17, dif17;

  // four long entries or eight short words
  assign ea    = en(st_q, 0);
  assign eb    = en(st_q, 1);
  assign ec    = en(st_q, 2);
  assign ed    = en(st_q, 3);
  assign w0    = wd(st_q, 0);
  assign w1    = wd(st_q, 1);
  // float result slot: the series core is outside this port
  assign fres  = ea;
  assign sa    = 64'($signed(ea));
  assign sb    = 64'($signed(eb));
  assign sw0   = 32'($signed(w0));
  assign sw1   = 32'($signed(w1));
  assign p32   = 64'(sa * sb);
  assign p16   = 32'(sw0 * sw1);
  // divide by zero gives zero rather than a trap
  assign q32   = (ea == UNDEF_ENT) ? UNDEF_ENT : 32'($signed(eb) / $signed(ea));
  assign q16   = (w0 == UNDEF_WRD) ? UNDEF_WRD : 16'($signed(w1) / $signed(w0));
  assign sum33 = {1'b0, ea} + {1'b0, eb};
  assign dif33 = {1'b0, eb} - {1'b0, ea};
  assign sum17 = {1'b0, w0} + {1'b0, w1};
  assign dif17 = {1'b0, w1} - {1'b0, w0};

  // bit seven is not part of the key
  always_comb begin
    st_nx    = st_q;
    carry_nx = 1'b0;
    case (cmd_q[6:0])
      OP_FLOAT_ADD, OP_FLOAT_SUB, OP_FLOAT_MUL, OP_FLOAT_DIV:
        st_nx = {fres, ec, ed, UNDEF_ENT};
      OP_FLOAT_ROOT:
        st_nx = {fres, eb, ec, UNDEF_ENT};
      OP_FLOAT_SIN, OP_FLOAT_COS, OP_FLOAT_TAN, OP_FLOAT_ATAN,
      OP_FLOAT_LOG10, OP_FLOAT_LN, OP_FLOAT_EXP:
        st_nx = {fres, eb, UNDEF_ENT, UNDEF_ENT};
      OP_FLOAT_ASIN, OP_FLOAT_ACOS:
        st_nx = {fres, UNDEF_ENT, UNDEF_ENT, UNDEF_ENT};
      OP_FLOAT_POWER:
        st_nx = {fres, ec, UNDEF_ENT, UNDEF_ENT};
      OP_FLOAT_NEGATE:
        st_nx = {ea ^ SIGN_MASK, eb, ec, ed};
      OP_FLOAT_DUP, OP_LONG_DUP:
        st_nx = {ea, ea, eb, ec};
      OP_FLOAT_POP, OP_LONG_POP:
        st_nx = {eb, ec, ed, ea};
      OP_FLOAT_SWAP, OP_LONG_SWAP:
        st_nx = {eb, ea, ec, ed};
      OP_PUSH_PI:
        st_nx = {PI_CONST, ea, eb, ec};
      OP_LONG_TO_FLOAT, OP_SHORT_TO_FLOAT, OP_FLOAT_TO_LONG:
        st_nx = {fres, eb, ec, UNDEF_ENT};
      OP_FLOAT_TO_SHORT:
        st_nx = {fres[WORD_W-1:0], eb, ec, UNDEF_WRD, UNDEF_ENT};
      OP_LONG_ADD: begin
        st_nx    = {sum33[31:0], ec, ed, ea};
        carry_nx = sum33[32];
      end
      OP_LONG_SUB: begin
        st_nx    = {dif33[31:0], ec, ed, ea};
        carry_nx = dif33[32];
      end
      OP_LONG_MUL_LOW:
        st_nx = {p32[31:0], ec, ed, UNDEF_ENT};
      OP_LONG_MUL_HIGH:
        st_nx = {p32[63:32], ec, ed, UNDEF_ENT};
      OP_LONG_DIV:
        st_nx = {q32, ec, ed, UNDEF_ENT};
      OP_LONG_NEGATE:
        st_nx = {32'(-ea), eb, ec, ed};
      OP_SHORT_ADD: begin
        st_nx    = {sum17[15:0], st_q[LOW_W-1:0], w0};
        carry_nx = sum17[16];
      end
      OP_SHORT_SUB: begin
        st_nx    = {dif17[15:0], st_q[LOW_W-1:0], w0};
        carry_nx = dif17[16];
      end
      OP_SHORT_MUL_LOW:
        st_nx = {p16[15:0], st_q[LOW_W-1:0], UNDEF_WRD};
      OP_SHORT_MUL_HIGH:
        st_nx = {p16[31:16], st_q[LOW_W-1:0], UNDEF_WRD};
      OP_SHORT_DIV:
        st_nx = {q16, st_q[LOW_W-1:0], UNDEF_WRD};
      OP_SHORT_NEGATE:
        st_nx = {16'(-w0), st_q[ST_W-WORD_W-1:0]};
      OP_SHORT_DUP:
        st_nx = {w0, st_q[ST_W-1:WORD_W]};
      OP_SHORT_POP:
        st_nx = {st_q[ST_W-WORD_W-1:0], w0};
      OP_SHORT_SWAP:
        st_nx = {w1, w0, st_q[LOW_W-1:0]};
      OP_NOP:
        st_nx = st_q;
      // illegal combinations leave the stack alone
      default:
        st_nx = st_q;
    endcase
  end

  // flags follow the format: short top word or long entry
  always_comb begin
    if (cmd_q.fixed && cmd_q.single) begin
      sign_nx = st_nx[ST_W-1];
      zero_nx = (wd(st_nx, 0) == UNDEF_WRD);
    end else begin
      sign_nx = st_nx[ST_W-1];
      zero_nx = (en(st_nx, 0) == UNDEF_ENT);
    end
  end

  // ------------------------------------------
  // handshake outputs
  // ------------------------------------------
  smc_flag u_done (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (done_pulse),
    .clr_i  (!done_ack_n_i || acc_start),
    .flag_o (done_oe_o)
  );

  smc_flag u_svc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (done_pulse && cmd_q.svc),
    .clr_i  (!svc_ack_n_i || cmd_take
             || (done_pulse && !cmd_q.svc)),
    .flag_o (svc_request_o)
  );

  // open drain: only ever pulls low
  assign done_n_o  = 1'b0;
  assign data_oe_o = !cs_n_i && !rd_n_i;
  // a buffer full stall also counts, so no write is dropped
  assign stall     = stat_q.busy || (eng_q != ENG_IDLE) || !in_rdy;
  assign ready_o   = (eng_q != ENG_RESET) && !(wr_act && stall) && !(rd_dat && !latched_q);

  // read data register: status or data latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
    end else begin
      data_o <= cmd_data_select_i ? 8'(stat_q) : rd_latch_q;
    end
  end

  // ------------------------------------------
  // checks
  // ------------------------------------------
  a_oe_in_read:
    assert property (@(posedge clk_i) disable iff (rst_i) data_oe_o |-> !cs_n_i && !rd_n_i)
    else $error("data bus driven outside a read");
  a_reset_span:
    assert property (@(posedge clk_i) $fell(rst_i) |-> (!ready_o && !stat_q.busy)[*5]
                     ##1 (eng_q == ENG_IDLE))
    else $error("reset span not five cycles");
  a_end_one_pulse:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     done_pulse ##1 !done_ack_n_i |=> !done_oe_o)
    else $error("done not cleared by ack");
  a_end_by_access:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     done_oe_o && acc_start && !done_pulse |=> !done_oe_o)
    else $error("access left done set");
  a_svc_raise:
    assert property (@(posedge clk_i) disable iff (rst_i) done_pulse && cmd_q.svc |=> svc_request_o)
    else $error("service request missing");
  a_svc_quiet:
    assert property (@(posedge clk_i) disable iff (rst_i) done_pulse && !cmd_q.svc |=> !svc_request_o)
    else $error("service request without bit seven");
  a_busy_stall:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     stat_q.busy && (wr_act || rd_dat) |-> !ready_o)
    else $error("ready high during busy access");
  a_exec_span:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     cmd_take |=> stat_q.busy[*8] ##1 (!stat_q.busy && done_oe_o))
    else $error("busy and done out of step");
  a_read_move:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     rd_move |-> !ready_o ##1 (ready_o || !rd_dat))
    else $error("read stall not one cycle");
  a_pop_rotate:
    assert property (@(posedge clk_i) disable iff (rst_i) rd_move |=>
                     st_q[BYTE_W-1:0] == $past(st_q[ST_W-1 -: BYTE_W]) && rd_latch_q == st_q[BYTE_W-1:0])
    else $error("popped byte not rotated");
  a_cmd_clr_svc:
    assert property (@(posedge clk_i) disable iff (rst_i) cmd_take |=> !svc_request_o)
    else $error("stale service request");
  a_nop_stable:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     done_pulse && cmd_q[6:0] == OP_NOP |=> $stable(st_q))
    else $error("no-operation changed stack");
endmodule
`default_nettype wire

// *** smc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------
// host side of the parallel bus
// -----------------------------------------
module smc_host_model (
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  input  wire logic [7:0] bus_i,
  output logic            cs_n_o,
  output logic            sel_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [7:0] wdata_o
);
  // idle bus: nothing selected
  initial begin
    cs_n_o = 1'b1;
    sel_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wdata_o = 8'h00;
  end

  // one access; strobe held until ready seen high, so a stalled byte is never dropped
  task automatic access(input logic sel, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdat, output logic stall);
    stall = 1'b0;
    @(posedge clk_i);
    #1;
    cs_n_o = 1'b0;
    sel_o = sel;
    rd_n_o = !rd;
    wr_n_o = rd;
    wdata_o = wd;
    repeat (2) @(posedge clk_i);
    #1;
    while (!ready_i) begin
      stall = 1'b1;
      @(posedge clk_i);
      #1;
    end
    // reads need one more edge before the latch reaches the pins
    repeat (rd ? 2 : 1) @(posedge clk_i);
    #1;
    rdat = bus_i;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wdata_o = ~wd; // released bus: never shows the old byte
    repeat (2) @(posedge clk_i);
    // step off the edge so callers never race the design's updates
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb_smc_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_smc_port;
  logic       clk, rst, ack_n, sack_n, cs_n, sel, rd_n, wr_n, oe, done_oe, done_n, svc, rdy, st;
  logic [7:0] wd, dout, r, n;
  int         fails = 0;
  int         checks_done = 0;
  int         cyc = 0;
  wire logic [7:0] bus = oe ? dout : wd;
  wire logic       end_pin = done_oe ? done_n : 1'b1; // open drain with pull-up

  smc_port DUT (.clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .cmd_data_select_i(sel), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .data_i(bus), .data_o(dout), .data_oe_o(oe), .done_ack_n_i(ack_n),
    .svc_ack_n_i(sack_n), .done_n_o(done_n), .done_oe_o(done_oe), .svc_request_o(svc), .ready_o(rdy));
  smc_host_model host (.clk_i(clk), .ready_i(rdy), .bus_i(bus), .cs_n_o(cs_n), .sel_o(sel),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_o(wd));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic s, input logic [7:0] b);
    host.access(s, 1'b0, b, r, st);
  endtask

  task automatic rd(input logic s);
    host.access(s, 1'b1, 8'h00, r, st);
  endtask

  task automatic push_long(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(1'b0, v[8*i +: 8]);
  endtask

  // pop one long entry, most significant byte first
  task automatic pop_long(input logic [31:0] exp);
    for (int i = 3; i >= 0; i--) begin
      rd(1'b0);
      chk(r, exp[8*i +: 8]);
    end
  endtask

  // also used mid-command: an aborted command must never signal completion
  task automatic t_reset();
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({7'h0, rdy}, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    chk({7'h0, rdy}, 8'h01);
    rd(1'b1);
    chk(r, 8'h00);
    chk({7'h0, done_oe}, 8'h00);
    $display("reset test done");
  endtask

  // full stack of bytes, then one pop beyond: the first byte popped (the last pushed) must come round again
  task automatic t_push_pop();
    for (int i = 0; i < 16; i++) wr(1'b0, 8'h10 + 8'(i));
    for (int i = 0; i < 17; i++) begin
      rd(1'b0);
      chk(r, 8'h1F - 8'(i % 16));
    end
    $display("push pop test done");
  endtask

  // long add with service flag, popped while still busy
  task automatic t_long();
    push_long(32'h0000_0001);
    push_long(32'h0000_0002);
    wr(1'b1, 8'hAC);
    rd(1'b0);
    chk({7'h0, st}, 8'h01);
    chk(r, 8'h00);
    chk({7'h0, svc}, 8'h01);
    for (int i = 0; i < 3; i++) rd(1'b0);
    chk(r, 8'h03);
    rd(1'b1);
    chk(r, 8'h00);
    sack_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    sack_n = 1'b1;
    chk({7'h0, svc}, 8'h00);
    $display("long test done");
  endtask

  task automatic t_done();
    wr(1'b1, 8'h80);
    for (int i = 0; i < 40 && done_oe !== 1'b1; i++) @(posedge clk);
    #1;
    chk({7'h0, end_pin}, 8'h00);
    chk({7'h0, svc}, 8'h01);
    rd(1'b1);
    chk({7'h0, end_pin}, 8'h01);
    ack_n = 1'b0;
    wr(1'b1, 8'h00);
    @(posedge clk);
    #1;
    chk({7'h0, svc}, 8'h00);
    n = 8'h00;
    // held acknowledge: completion may show for exactly one cycle
    repeat (30) begin
      @(posedge clk);
      #1;
      n = n + {7'h0, done_oe};
    end
    ack_n = 1'b1;
    chk(n, 8'h01);
    chk({7'h0, svc}, 8'h00);
    $display("done test done");
  endtask

  // short subtract: second word minus top word
  task automatic t_short();
    wr(1'b0, 8'h05);
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h03);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h6D);
    rd(1'b0);
    chk(r, 8'h00);
    rd(1'b0);
    chk(r, 8'h02);
    $display("short test done");
  endtask

  // long divide, commands entered while busy, stack kept over a reset
  task automatic t_ops();
    push_long(32'h0000_0015);
    push_long(32'h0000_0003);
    wr(1'b1, 8'h2F);
    wr(1'b1, 8'h1A);
    chk({7'h0, st}, 8'h01);
    wr(1'b1, 8'h19);
    wr(1'b1, 8'h15);
    pop_long(32'h8000_0007);
    rd(1'b1);
    chk(r, 8'h40);
    t_reset();
    pop_long(smc_pkg::PI_CONST);
    $display("ops test done");
  endtask

  // bus drive only while selected and reading
  always @(negedge clk) begin
    if (!rst) chk({7'h0, oe}, {7'h0, !cs_n && !rd_n});
  end

  // hang guard, well above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    ack_n = 1'b1;
    sack_n = 1'b1;
    t_reset();
    t_push_pop();
    t_long();
    t_done();
    t_short();
    t_ops();
    wr(1'b1, 8'h2C);
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
